// [hw/nvm_external_program_commands.sv]
// Command decoder and sequencer of the nonvolatile memory controller, programming-port side.
// Assumes a memory backend that performs erase, write, CRC and read and reports completion.
//
// What this block does
// [R1] Action commands start on command_execute_bit.
// [R2] Read commands run on a port load.
// [R3] Write commands run on a port store.
// [R4] Full lock allows only chip erase, flash CRC.
// [R5] Chip erase: flash, EEPROM, lock bits only.
// [R6] Preserve fuse keeps EEPROM through chip erase.
// [R7] Chip erase disconnects bus, clears enabled bit.
// [R8] Programmer waits for enabled bit after erase.
// [R9] Busy set throughout chip erase.
// [R10] Generic read returns addressed byte, no busy.
// [R11] Dedicated reads behave like generic read.
// [R12] Buffer erase on execute bit, busy until done.
// [R13] Buffer load stores one byte, no busy.
// [R14] Programmer writes low byte before high byte.
// [R15] Low byte held, committed with high byte.
// [R16] Port stalls after a buffer load store.
// [R17] Flash page commands on store, with busy.
// [R18] Application commands on store, with busy.
// [R19] Boot commands on store, with busy.
// [R20] CRC commands on execute bit, with busy.
// [R21] User signature erase/write on store, busy.
// [R22] EEPROM erase/write commands busy; whole erase on execute.
// [R23] Loads blocked while memory is busy.
// [R24] Programmer enables interface before commands.
// [R25] Store anywhere in page selects that page.
// [R26] Unknown or zero code does nothing.
`include "nvm_cmd_consts.svh"
module nvm_external_program_commands
  import nvm_cmd_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Command register and protection inputs
  input wire logic [`CMD_W-1:0] cmd_code,
  input wire logic command_execute_bit,
  input wire logic read_lock,
  input wire logic write_lock,
  input wire logic eeprom_preserve_fuse,
  input wire logic interface_unlocked,
  // Programming port access
  input wire logic port_valid,
  input wire logic port_write,
  input wire logic [`ADDR_W-1:0] port_addr,
  input wire logic [`DATA_W-1:0] port_wdata,
  output logic port_ready,
  output logic port_rvalid,
  output logic [`DATA_W-1:0] port_rdata,
  // Status
  output logic busy,
  output logic memory_interface_enabled,
  output logic cmd_rejected,
  // Memory backend operation
  output logic mem_start,
  output logic [`CMD_W-1:0] mem_cmd,
  output logic [`ADDR_W-1:0] mem_addr,
  output logic [`DATA_W-1:0] mem_wdata,
  output logic mem_erase_flash,
  output logic mem_erase_eeprom,
  output logic mem_erase_lock,
  input wire logic mem_done,
  // Memory backend read
  output logic mem_rd_req,
  input wire logic mem_rd_valid,
  input wire logic [`DATA_W-1:0] mem_rd_data,
  // Page buffer readout for the backend
  input wire logic [`FLASH_IDX_W-1:0] flash_buf_rd_idx,
  output logic [`FLASH_WORD_W-1:0] flash_buf_rd_word,
  input wire logic [`EE_IDX_W-1:0] ee_buf_rd_idx,
  output logic [`DATA_W-1:0] ee_buf_rd_byte
);

  function automatic cmd_kind_t kind_of(input logic [`CMD_W-1:0] c);
    case (c)
      `CMD_CHIP_ERASE, `CMD_ERASE_FLASH_BUF, `CMD_FLASH_CRC, `CMD_APP_CRC, `CMD_BOOT_CRC,
      `CMD_WRITE_LOCK, `CMD_ERASE_EE_BUF, `CMD_ERASE_EE: kind_of = K_ACTION;
      `CMD_READ_NVM, `CMD_READ_USER_SIG, `CMD_READ_PROD_SIG, `CMD_READ_FUSE,
      `CMD_READ_EE: kind_of = K_READ;
      `CMD_LOAD_FLASH_BUF, `CMD_LOAD_EE_BUF: kind_of = K_BUF_LOAD;
      `CMD_ERASE_FLASH_PAGE, `CMD_WRITE_FLASH_PAGE, `CMD_ERASE_WRITE_FLASH_PAGE,
      `CMD_ERASE_APP, `CMD_ERASE_APP_PAGE, `CMD_WRITE_APP_PAGE, `CMD_ERASE_WRITE_APP_PAGE,
      `CMD_ERASE_BOOT, `CMD_ERASE_BOOT_PAGE, `CMD_WRITE_BOOT_PAGE, `CMD_ERASE_WRITE_BOOT_PAGE,
      `CMD_ERASE_USER_SIG, `CMD_WRITE_USER_SIG, `CMD_WRITE_FUSE, `CMD_ERASE_EE_PAGE,
      `CMD_WRITE_EE_PAGE, `CMD_ERASE_WRITE_EE_PAGE: kind_of = K_MEM_WRITE;
      default: kind_of = K_NOP;
    endcase
  endfunction

  // Page commands address the whole page, so the offset inside it is dropped.
  function automatic logic [`ADDR_W-1:0] page_of(input logic [`CMD_W-1:0] c,
                                                 input logic [`ADDR_W-1:0] a);
    case (c)
      `CMD_ERASE_FLASH_PAGE, `CMD_WRITE_FLASH_PAGE, `CMD_ERASE_WRITE_FLASH_PAGE,
      `CMD_ERASE_APP_PAGE, `CMD_WRITE_APP_PAGE, `CMD_ERASE_WRITE_APP_PAGE,
      `CMD_ERASE_BOOT_PAGE, `CMD_WRITE_BOOT_PAGE, `CMD_ERASE_WRITE_BOOT_PAGE,
      `CMD_ERASE_USER_SIG, `CMD_WRITE_USER_SIG:
        page_of = {a[`ADDR_W-1:`FLASH_PAGE_LSB], {`FLASH_PAGE_LSB{1'b0}}}; // [R25]
      `CMD_ERASE_EE_PAGE, `CMD_WRITE_EE_PAGE, `CMD_ERASE_WRITE_EE_PAGE:
        page_of = {a[`ADDR_W-1:`EE_PAGE_LSB], {`EE_PAGE_LSB{1'b0}}}; // [R25]
      default: page_of = a;
    endcase
  endfunction

  page_buf_if #(.W(`FLASH_WORD_W), .IW(`FLASH_IDX_W)) flash_bus ();
  page_buf_if #(.W(`DATA_W), .IW(`EE_IDX_W)) ee_bus ();

  page_buffer #(.W(`FLASH_WORD_W), .IW(`FLASH_IDX_W)) flash_buf (
    .clk_sys(clk_sys),
    .bus(flash_bus.store)
  );

  page_buffer #(.W(`DATA_W), .IW(`EE_IDX_W)) ee_buf (
    .clk_sys(clk_sys),
    .bus(ee_bus.store)
  );

  seq_state_t state_q, state_d;
  logic [`CMD_W-1:0] cmd_q, cmd_d;
  logic [`ADDR_W-1:0] addr_q, addr_d;
  logic [`DATA_W-1:0] wdata_q, wdata_d;
  logic [`DATA_W-1:0] lo_q, lo_d;
  logic [`DATA_W-1:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic start_q, start_d;
  logic rd_req_q, rd_req_d;
  logic reject_q, reject_d;
  logic chip_erase_q, chip_erase_d;
  logic er_flash_q, er_flash_d;
  logic er_ee_q, er_ee_d;
  logic er_lock_q, er_lock_d;
  logic clr_flash_q, clr_flash_d;
  logic [`FLASH_IDX_W-1:0] clr_idx_q, clr_idx_d;

  logic fwr_en, ewr_en;
  logic [`FLASH_IDX_W-1:0] fwr_addr;
  logic [`EE_IDX_W-1:0] ewr_addr;
  logic [`FLASH_WORD_W-1:0] fwr_data;
  logic [`DATA_W-1:0] ewr_data;

  cmd_kind_t kind;
  logic permitted;
  logic bus_on;
  logic take;

  assign kind = kind_of(cmd_code);
  // With both locks set only the two recovery commands may run.
  assign permitted = !(read_lock && write_lock) || cmd_code == `CMD_CHIP_ERASE ||
                     cmd_code == `CMD_FLASH_CRC; // [R4]
  assign bus_on = interface_unlocked && !chip_erase_q; // [R7]
  // An execute request in the same cycle has priority, so the port waits one cycle.
  assign port_ready = bus_on && state_q == S_IDLE && !command_execute_bit; // [R16] [R23]
  assign take = port_valid && port_ready;

  always_comb begin
    state_d = state_q;
    cmd_d = cmd_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    lo_d = lo_q;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    start_d = 1'b0;
    rd_req_d = 1'b0;
    reject_d = 1'b0;
    chip_erase_d = chip_erase_q;
    er_flash_d = er_flash_q;
    er_ee_d = er_ee_q;
    er_lock_d = er_lock_q;
    clr_flash_d = clr_flash_q;
    clr_idx_d = clr_idx_q;
    fwr_en = 1'b0;
    fwr_addr = port_addr[`FLASH_IDX_W:1];
    fwr_data = {port_wdata, lo_q};
    ewr_en = 1'b0;
    ewr_addr = port_addr[`EE_IDX_W-1:0];
    ewr_data = port_wdata;
    unique case (state_q)
      S_IDLE: begin
        if (command_execute_bit && bus_on) begin
          if (kind == K_ACTION && !permitted) begin
            reject_d = 1'b1; // [R4]
          end else if (kind == K_ACTION) begin
            cmd_d = cmd_code;
            if (cmd_code == `CMD_ERASE_FLASH_BUF || cmd_code == `CMD_ERASE_EE_BUF) begin
              clr_flash_d = cmd_code == `CMD_ERASE_FLASH_BUF; // [R12]
              clr_idx_d = '0;
              state_d = S_BUF_CLEAR;
            end else begin
              // Chip erase, CRC, whole EEPROM erase and lock write go to the backend.
              start_d = 1'b1; // [R1] [R20] [R22]
              state_d = S_MEM_OP;
              if (cmd_code == `CMD_CHIP_ERASE) begin
                chip_erase_d = 1'b1; // [R7] [R9]
                er_flash_d = 1'b1; // [R5]
                er_ee_d = !eeprom_preserve_fuse; // [R5] [R6]
                er_lock_d = 1'b1; // [R5]
              end
            end
          end
        end else if (take && !port_write) begin
          if (kind == K_READ && permitted) begin
            cmd_d = cmd_code;
            addr_d = port_addr;
            rd_req_d = 1'b1; // [R2] [R10] [R11]
            state_d = S_READ_WAIT;
          end else begin
            // A load that starts nothing still answers, so the port never hangs.
            rdata_d = `EMPTY_READ; // [R26]
            rvalid_d = 1'b1;
            reject_d = kind != K_NOP && !permitted;
          end
        end else if (take && port_write) begin
          if (kind == K_BUF_LOAD && permitted) begin
            if (cmd_code == `CMD_LOAD_EE_BUF) begin
              ewr_en = 1'b1; // [R13]
            end else if (!port_addr[0]) begin
              lo_d = port_wdata; // [R15]
            end else begin
              fwr_en = 1'b1; // [R15]
            end
            state_d = S_BUF_STALL; // [R16]
          end else if (kind == K_MEM_WRITE && permitted) begin
            cmd_d = cmd_code;
            addr_d = page_of(cmd_code, port_addr); // [R25]
            wdata_d = port_wdata;
            er_flash_d = 1'b0;
            er_ee_d = 1'b0;
            er_lock_d = 1'b0;
            start_d = 1'b1; // [R3] [R17] [R18] [R19] [R21] [R22]
            state_d = S_MEM_OP;
          end else begin
            reject_d = kind != K_NOP && !permitted; // [R26]
          end
        end
      end
      S_BUF_STALL: begin
        state_d = S_IDLE; // [R16]
      end
      S_READ_WAIT: begin
        if (mem_rd_valid) begin
          rdata_d = mem_rd_data; // [R10]
          rvalid_d = 1'b1;
          state_d = S_IDLE;
        end
      end
      S_MEM_OP: begin
        if (mem_done) begin
          chip_erase_d = 1'b0; // [R7] [R9]
          er_flash_d = 1'b0;
          er_ee_d = 1'b0;
          er_lock_d = 1'b0;
          state_d = S_IDLE;
        end
      end
      S_BUF_CLEAR: begin
        // One entry per cycle keeps a single write port on each buffer.
        fwr_en = clr_flash_q;
        fwr_addr = clr_idx_q;
        fwr_data = {`ERASED_BYTE, `ERASED_BYTE};
        ewr_en = !clr_flash_q;
        ewr_addr = clr_idx_q[`EE_IDX_W-1:0];
        ewr_data = `ERASED_BYTE;
        clr_idx_d = clr_idx_q + 1'b1;
        if ((clr_flash_q && clr_idx_q == `FLASH_BUF_LAST) ||
            (!clr_flash_q && clr_idx_q[`EE_IDX_W-1:0] == `EE_BUF_LAST)) begin
          state_d = S_IDLE; // [R12]
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= S_IDLE;
      cmd_q <= `CMD_NOP;
      addr_q <= '0;
      wdata_q <= '0;
      lo_q <= `ERASED_BYTE;
      rdata_q <= '0;
      rvalid_q <= 1'b0;
      start_q <= 1'b0;
      rd_req_q <= 1'b0;
      reject_q <= 1'b0;
      chip_erase_q <= 1'b0;
      er_flash_q <= 1'b0;
      er_ee_q <= 1'b0;
      er_lock_q <= 1'b0;
      clr_flash_q <= 1'b0;
      clr_idx_q <= '0;
    end else begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      lo_q <= lo_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      start_q <= start_d;
      rd_req_q <= rd_req_d;
      reject_q <= reject_d;
      chip_erase_q <= chip_erase_d;
      er_flash_q <= er_flash_d;
      er_ee_q <= er_ee_d;
      er_lock_q <= er_lock_d;
      clr_flash_q <= clr_flash_d;
      clr_idx_q <= clr_idx_d;
    end
  end

  assign flash_bus.wr_en = fwr_en;
  assign flash_bus.wr_addr = fwr_addr;
  assign flash_bus.wr_data = fwr_data;
  assign flash_bus.rd_addr = flash_buf_rd_idx;
  assign ee_bus.wr_en = ewr_en;
  assign ee_bus.wr_addr = ewr_addr;
  assign ee_bus.wr_data = ewr_data;
  assign ee_bus.rd_addr = ee_buf_rd_idx;
  assign flash_buf_rd_word = flash_bus.rd_data;
  assign ee_buf_rd_byte = ee_bus.rd_data;

  // Reads and buffer loads never raise busy; only backend work and buffer erase do.
  assign busy = state_q == S_MEM_OP || state_q == S_BUF_CLEAR; // [R9] [R12] [R17]
  assign memory_interface_enabled = bus_on; // [R7]
  assign cmd_rejected = reject_q;
  assign port_rvalid = rvalid_q;
  assign port_rdata = rdata_q;
  assign mem_start = start_q;
  assign mem_cmd = cmd_q;
  assign mem_addr = addr_q;
  assign mem_wdata = wdata_q;
  assign mem_erase_flash = er_flash_q;
  assign mem_erase_eeprom = er_ee_q;
  assign mem_erase_lock = er_lock_q;
  assign mem_rd_req = rd_req_q;
endmodule // nvm_external_program_commands

// [hw/nvm_cmd_consts.svh]
// Command codes, buffer geometry and fixed values of the programming command sequencer.
// Assumes it is included by bare name from the package and the design modules.
`ifndef NVM_CMD_CONSTS_SVH
`define NVM_CMD_CONSTS_SVH

`define CMD_W 7
`define ADDR_W 24
`define DATA_W 8

`define CMD_NOP 7'h00
`define CMD_CHIP_ERASE 7'h40
`define CMD_READ_NVM 7'h43
`define CMD_LOAD_FLASH_BUF 7'h23
`define CMD_ERASE_FLASH_BUF 7'h26
`define CMD_ERASE_FLASH_PAGE 7'h2B
`define CMD_WRITE_FLASH_PAGE 7'h2E
`define CMD_ERASE_WRITE_FLASH_PAGE 7'h2F
`define CMD_FLASH_CRC 7'h78
`define CMD_ERASE_APP 7'h20
`define CMD_ERASE_APP_PAGE 7'h22
`define CMD_WRITE_APP_PAGE 7'h24
`define CMD_ERASE_WRITE_APP_PAGE 7'h25
`define CMD_APP_CRC 7'h38
`define CMD_ERASE_BOOT 7'h68
`define CMD_ERASE_BOOT_PAGE 7'h2A
`define CMD_WRITE_BOOT_PAGE 7'h2C
`define CMD_ERASE_WRITE_BOOT_PAGE 7'h2D
`define CMD_BOOT_CRC 7'h39
`define CMD_READ_USER_SIG 7'h01
`define CMD_ERASE_USER_SIG 7'h18
`define CMD_WRITE_USER_SIG 7'h1A
`define CMD_READ_PROD_SIG 7'h02
`define CMD_READ_FUSE 7'h07
`define CMD_READ_EE 7'h06
`define CMD_WRITE_FUSE 7'h4C
`define CMD_WRITE_LOCK 7'h08
`define CMD_LOAD_EE_BUF 7'h33
`define CMD_ERASE_EE_BUF 7'h36
`define CMD_ERASE_EE 7'h30
`define CMD_ERASE_EE_PAGE 7'h32
`define CMD_WRITE_EE_PAGE 7'h34
`define CMD_ERASE_WRITE_EE_PAGE 7'h35

// Flash page buffer: 128 words of 16 bits, 256 bytes per page.
`define FLASH_WORD_W 16
`define FLASH_IDX_W 7
`define FLASH_BUF_LAST 7'h7F
`define FLASH_PAGE_LSB 8
// EEPROM page buffer: 32 bytes.
`define EE_IDX_W 5
`define EE_BUF_LAST 5'h1F
`define EE_PAGE_LSB 5

`define ERASED_BYTE 8'hFF
`define EMPTY_READ 8'h00

`endif

// [hw/nvm_cmd_pkg.sv]
// Types shared by the command sequencer.
// Assumes nvm_cmd_consts.svh is on the include path.
`include "nvm_cmd_consts.svh"

package nvm_cmd_pkg;

  typedef enum {
    S_IDLE,
    S_BUF_STALL,
    S_READ_WAIT,
    S_MEM_OP,
    S_BUF_CLEAR
  } seq_state_t;

  typedef enum {
    K_NOP,
    K_ACTION,
    K_READ,
    K_BUF_LOAD,
    K_MEM_WRITE
  } cmd_kind_t;

endpackage

// [hw/page_buf_if.sv]
// Port bundle between the sequencer and one page buffer memory.
// Assumes one writer (the sequencer) and one memory on the other side.
interface page_buf_if #(
  parameter int W = 16,
  parameter int IW = 7
);
  logic wr_en;
  logic [IW-1:0] wr_addr;
  logic [W-1:0] wr_data;
  logic [IW-1:0] rd_addr;
  logic [W-1:0] rd_data;

  modport owner (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// [hw/page_buffer.sv]
// Page buffer memory: one write port, one registered read port.
// Assumes the writer never needs the written word back in the same cycle.
module page_buffer #(
  parameter int W = 16,
  parameter int IW = 7
) (
  // Clock
  input wire logic clk_sys,
  // Buffer access
  page_buf_if.store bus
);
  logic [W-1:0] mem [0:(1<<IW)-1];
  logic [W-1:0] rd_q;

  always_ff @(posedge clk_sys) begin
    if (bus.wr_en) begin
      mem[bus.wr_addr] <= bus.wr_data;
    end
    rd_q <= mem[bus.rd_addr];
  end

  assign bus.rd_data = rd_q;
endmodule // page_buffer

// [sim/mem_backend_model.sv]
// Behavioural memory backend answering operation starts and read requests.
// Assumes it sits on the sequencer's backend ports; slow lengthens every answer.
`include "nvm_cmd_consts.svh"

module mem_backend_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Pacing
  input wire logic slow,
  // Requests from the sequencer
  input wire logic mem_start,
  input wire logic mem_rd_req,
  input wire logic [`ADDR_W-1:0] mem_addr,
  // Answers
  output logic mem_done,
  output logic mem_rd_valid,
  output logic [`DATA_W-1:0] mem_rd_data
);
  int op_cnt;
  int rd_cnt;

  initial begin
    mem_done = 1'b0;
    mem_rd_valid = 1'b0;
    mem_rd_data = 8'h00;
  end

  // The read data toggles outside an answer so a stale value never passes as a match.
  always @(posedge clk_sys) begin
    mem_done <= 1'b0;
    mem_rd_valid <= 1'b0;
    mem_rd_data <= ~mem_rd_data;
    if (reset) begin
      op_cnt <= 0;
      rd_cnt <= 0;
    end else begin
      if (mem_start === 1'b1) op_cnt <= slow ? 40 : 3;
      else if (op_cnt > 0) op_cnt <= op_cnt - 1;
      if (op_cnt == 1) mem_done <= 1'b1;
      if (mem_rd_req === 1'b1) rd_cnt <= slow ? 9 : 2;
      else if (rd_cnt > 0) rd_cnt <= rd_cnt - 1;
      if (rd_cnt == 1) begin
        mem_rd_valid <= 1'b1;
        mem_rd_data <= mem_addr[7:0] ^ 8'h5A;
      end
    end
  end
endmodule // mem_backend_model

// [sim/nvm_cmd_checker.sv]
// Port-level assertions for the command sequencer.
// Assumes the sequencer's top ports and the shared command constants.
`include "nvm_cmd_consts.svh"

module nvm_cmd_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Inputs
  input wire logic [`CMD_W-1:0] cmd_code,
  input wire logic read_lock,
  input wire logic write_lock,
  input wire logic eeprom_preserve_fuse,
  input wire logic port_valid,
  input wire logic port_write,
  input wire logic [`ADDR_W-1:0] port_addr,
  // Outputs
  input wire logic port_ready,
  input wire logic port_rvalid,
  input wire logic [`DATA_W-1:0] port_rdata,
  input wire logic busy,
  input wire logic memory_interface_enabled,
  input wire logic cmd_rejected,
  input wire logic mem_start,
  input wire logic [`CMD_W-1:0] mem_cmd,
  input wire logic [`ADDR_W-1:0] mem_addr,
  input wire logic mem_erase_flash,
  input wire logic mem_erase_eeprom,
  input wire logic mem_erase_lock,
  input wire logic mem_rd_req
);
  logic take_ld;
  logic take_st;
  logic locked;
  assign take_ld = port_valid && port_ready && !port_write;
  assign take_st = port_valid && port_ready && port_write;
  assign locked = read_lock && write_lock;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  read_start_a: assert property (take_ld && !locked && cmd_code == `CMD_READ_NVM |=>
    mem_rd_req && !busy) else $error("read load did not request memory");
  lock_load_a: assert property (take_ld && locked |=>
    port_rvalid && port_rdata == `EMPTY_READ && !mem_rd_req) else $error("locked load answered");
  buf_stall_a: assert property (take_st && !locked &&
    cmd_code inside {`CMD_LOAD_FLASH_BUF, `CMD_LOAD_EE_BUF} |=>
    !port_ready && !busy && !mem_start) else $error("buffer load not stalled");
  page_start_a: assert property (take_st && !locked &&
    cmd_code inside {7'h2B, 7'h2E, 7'h2F, 7'h22, 7'h24, 7'h25, 7'h2A, 7'h2C, 7'h2D} |=>
    mem_start && busy && mem_cmd == $past(cmd_code)
    && mem_addr == ($past(port_addr) & 24'hFFFF00)) else $error("page store start wrong");
  lock_reject_a: assert property (take_st && locked &&
    cmd_code == `CMD_WRITE_FLASH_PAGE |=> cmd_rejected && !mem_start && !busy)
    else $error("locked store not rejected");
  nop_quiet_a: assert property (take_st && cmd_code == `CMD_NOP |=>
    !mem_start && !busy && !cmd_rejected ##1 !busy) else $error("no-op store acted");
  erase_flags_a: assert property (mem_start && mem_cmd == `CMD_CHIP_ERASE |->
    mem_erase_flash && mem_erase_lock && mem_erase_eeprom == !eeprom_preserve_fuse && busy
    && !memory_interface_enabled && !port_ready) else $error("chip erase start wrong");
  erase_off_a: assert property (busy && mem_erase_flash |->
    !memory_interface_enabled && !port_ready) else $error("bus open during chip erase");
  other_flags_a: assert property (mem_start && mem_cmd != `CMD_CHIP_ERASE |->
    !mem_erase_flash && !mem_erase_eeprom && !mem_erase_lock)
    else $error("erase flag on other op");
endmodule // nvm_cmd_checker

bind nvm_external_program_commands nvm_cmd_checker chk (.clk_sys, .reset, .cmd_code, .read_lock,
  .write_lock, .eeprom_preserve_fuse, .port_valid, .port_write, .port_addr, .port_ready,
  .port_rvalid, .port_rdata, .busy, .memory_interface_enabled, .cmd_rejected, .mem_start,
  .mem_cmd, .mem_addr, .mem_erase_flash, .mem_erase_eeprom, .mem_erase_lock, .mem_rd_req);

// [sim/nvm_external_program_commands_tb.sv]
// Self-checking bench: the bench plays the programmer, the model the memory backend.
// Assumes the design files and the backend model are compiled before it.
`include "nvm_cmd_consts.svh"

module nvm_external_program_commands_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [6:0] cmd_code = 7'h00;
  logic command_execute_bit = 1'b0;
  logic read_lock = 1'b0;
  logic write_lock = 1'b0;
  logic eeprom_preserve_fuse = 1'b0;
  logic interface_unlocked = 1'b0;
  logic port_valid = 1'b0;
  logic port_write = 1'b0;
  logic [23:0] port_addr = 24'h000000;
  logic [7:0] port_wdata = 8'h00;
  logic slow = 1'b0;
  logic [6:0] flash_buf_rd_idx = 7'h00;
  logic [4:0] ee_buf_rd_idx = 5'h00;
  logic port_ready, port_rvalid, busy, memory_interface_enabled, cmd_rejected, mem_start, ee_flag;
  logic mem_erase_flash, mem_erase_eeprom, mem_erase_lock, mem_done, mem_rd_req, mem_rd_valid;
  logic [7:0] port_rdata, mem_wdata, mem_rd_data, ee_buf_rd_byte, d;
  logic [6:0] mem_cmd;
  logic [23:0] mem_addr;
  logic [15:0] flash_buf_rd_word, w;
  logic [15:0] fbuf [128];
  logic [7:0] ebuf [32];
  logic [6:0] st_cmds [17] = '{7'h2B, 7'h2E, 7'h2F, 7'h20, 7'h22, 7'h24, 7'h25, 7'h68, 7'h2A,
    7'h2C, 7'h2D, 7'h18, 7'h1A, 7'h32, 7'h34, 7'h35, 7'h4C};
  logic [6:0] ex_cmds [6] = '{7'h40, 7'h78, 7'h38, 7'h39, 7'h30, 7'h08};
  logic [6:0] rd_cmds [5] = '{7'h43, 7'h06, 7'h07, 7'h01, 7'h02};
  int errors = 0;
  int compares = 0;
  int starts = 0;
  int rejects = 0;
  int n;

  nvm_external_program_commands dut (.clk_sys, .reset, .cmd_code, .command_execute_bit,
    .read_lock, .write_lock, .eeprom_preserve_fuse, .interface_unlocked, .port_valid, .port_write,
    .port_addr, .port_wdata, .port_ready, .port_rvalid, .port_rdata, .busy,
    .memory_interface_enabled, .cmd_rejected, .mem_start, .mem_cmd, .mem_addr, .mem_wdata,
    .mem_erase_flash, .mem_erase_eeprom, .mem_erase_lock, .mem_done, .mem_rd_req, .mem_rd_valid,
    .mem_rd_data, .flash_buf_rd_idx, .flash_buf_rd_word, .ee_buf_rd_idx, .ee_buf_rd_byte);
  mem_backend_model backend (.clk_sys, .reset, .slow, .mem_start, .mem_rd_req, .mem_addr,
    .mem_done, .mem_rd_valid, .mem_rd_data);

  always #5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    if (mem_start === 1'b1) starts++;
    if (mem_start === 1'b1) ee_flag <= mem_erase_eeprom;
    if (cmd_rejected === 1'b1) rejects++;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("Counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic wait_until(input logic ok, input int k);
    if (k == 400) begin
      errors++;
      conclude();
    end
  endtask

  // Polling the enabled bit also covers the wait after a chip erase.
  task automatic idle_wait();
    int k;
    k = 0;
    while (!(busy === 1'b0 && memory_interface_enabled === 1'b1 && port_ready === 1'b1)
           && k < 400) begin
      @(negedge clk_sys);
      k++;
    end
    wait_until(1'b1, k);
  endtask

  task automatic access(input logic wr, input logic [23:0] a, input logic [7:0] wd);
    int k;
    port_write = wr;
    port_addr = a;
    port_wdata = wd;
    port_valid = 1'b1;
    k = 0;
    while (port_ready !== 1'b1 && k < 400) begin
      @(negedge clk_sys);
      k++;
    end
    wait_until(1'b1, k);
    @(negedge clk_sys);
    port_valid = 1'b0;
    k = 0;
    while (!wr && port_rvalid !== 1'b1 && k < 400) begin
      @(negedge clk_sys);
      k++;
    end
    wait_until(1'b1, k);
    d = port_rdata;
    // One idle edge keeps the next call from raising valid in the step that lowered it.
    @(negedge clk_sys);
  endtask

  task automatic run_op(input logic [6:0] c, input logic ex, input logic go);
    int s0;
    int r0;
    idle_wait();
    s0 = starts;
    r0 = rejects;
    cmd_code = c;
    command_execute_bit = ex;
    if (ex) @(negedge clk_sys);
    else begin
      w = 16'($urandom);
      access(1'b1, {8'h00, w}, w[15:8]);
    end
    command_execute_bit = 1'b0;
    repeat (2) @(negedge clk_sys);
    check("start count", starts - s0, go);
    check("busy active", busy, go);
    check("reject count", rejects - r0, !go && c != `CMD_NOP);
    check("interface enabled", memory_interface_enabled, !(go && c == `CMD_CHIP_ERASE));
    if (go && c == `CMD_CHIP_ERASE) check("eeprom erase", ee_flag, !eeprom_preserve_fuse);
    if (go) check("backend cmd", mem_cmd, c);
    if (go && !ex) check("store data", mem_wdata, w[15:8]);
  endtask

  initial begin
    void'($urandom(32'hB9BAA505));
    repeat (20) @(negedge clk_sys);
    reset = 1'b0;
    check("busy after reset", busy, 1'b0);
    check("rdata after reset", port_rdata, 8'h00);
    interface_unlocked = 1'b1;
    for (int i = 0; i < 10; i++) begin
      read_lock = i >= 5;
      write_lock = i >= 5;
      slow = i[0];
      cmd_code = rd_cmds[i % 5];
      w = 16'($urandom);
      idle_wait();
      access(1'b0, {8'h08, w}, 8'h00);
      check("read data", d, i >= 5 ? 8'h00 : w[7:0] ^ 8'h5A);
    end
    $display("Test reads done");
    read_lock = 1'b0;
    write_lock = 1'b0;
    for (int b = 0; b < 2; b++) begin
      idle_wait();
      cmd_code = b ? `CMD_ERASE_EE_BUF : `CMD_ERASE_FLASH_BUF;
      command_execute_bit = 1'b1;
      @(negedge clk_sys);
      command_execute_bit = 1'b0;
      n = 0;
      while (busy === 1'b1 && n < 300) begin
        @(negedge clk_sys);
        n++;
      end
      check("buffer erase cycles", n, b ? 32 : 128);
    end
    foreach (fbuf[i]) fbuf[i] = 16'hFFFF;
    foreach (ebuf[i]) ebuf[i] = 8'hFF;
    for (int i = 0; i < 16; i++) begin
      w = 16'($urandom);
      n = $urandom % 128;
      cmd_code = `CMD_LOAD_FLASH_BUF;
      access(1'b1, {16'h0001, n[6:0], 1'b0}, w[7:0]);
      access(1'b1, {16'h0001, n[6:0], 1'b1}, w[15:8]);
      fbuf[n] = w;
      cmd_code = `CMD_LOAD_EE_BUF;
      access(1'b1, {16'h08C0, 3'h0, n[4:0]}, w[7:0]);
      ebuf[n % 32] = w[7:0];
    end
    for (int i = 0; i < 128; i++) begin
      flash_buf_rd_idx = i[6:0];
      ee_buf_rd_idx = i[4:0];
      @(negedge clk_sys);
      check("flash word", flash_buf_rd_word, fbuf[i]);
      check("eeprom byte", ee_buf_rd_byte, ebuf[i % 32]);
    end
    $display("Test buffers done");
    for (int k = 0; k < 2; k++) begin
      slow = k[0];
      foreach (st_cmds[i]) run_op(st_cmds[i], 1'b0, 1'b1);
      foreach (ex_cmds[i]) begin
        eeprom_preserve_fuse = k[0];
        run_op(ex_cmds[i], 1'b1, 1'b1);
      end
    end
    $display("Test operations done");
    read_lock = 1'b1;
    write_lock = 1'b1;
    foreach (st_cmds[i]) run_op(st_cmds[i], 1'b0, 1'b0);
    foreach (ex_cmds[i]) run_op(ex_cmds[i], 1'b1, ex_cmds[i] inside {7'h40, 7'h78});
    run_op(`CMD_NOP, 1'b0, 1'b0);
    run_op(`CMD_NOP, 1'b1, 1'b0);
    idle_wait();
    $display("Test locks done");
    conclude();
  end
endmodule // nvm_external_program_commands_tb
